//--- hw/tfsc_defines.svh
// What this block does
// - Illumination bit 6: with bit 7 at 0, 0 modulates light and 1 holds it on during integration
// - Illumination bit 7: 1 holds light off during integration whatever bit 6 is; 0 leaves bit 6 in control
// - Only bits 6 and 7 of illumination register matter; others reserved, ignored
// - Frames two to four each own a phase_sample/suppression select field
// - Frames two to four each own a modulation control field
// - Grayscale readout mode 0x00 selects differential readout
// - Grayscale readout mode 0x10 selects single-ended readout, negatives clipped to zero
// - Grayscale readout mode 0x30 selects differential readout with background_suppression
// - Grayscale frames use their own modulation control, not the distance frame fields
`ifndef TFSC_DEFINES_SVH
`define TFSC_DEFINES_SVH

// Register indices, byte address is four times the index
`define TFSC_IDX_ILLUM      8'h27
`define TFSC_IDX_SEL2       8'h28
`define TFSC_IDX_MOD2       8'h29
`define TFSC_IDX_SEL3       8'h2a
`define TFSC_IDX_MOD3       8'h2b
`define TFSC_IDX_SEL4       8'h2d
`define TFSC_IDX_MOD4       8'h2e
`define TFSC_IDX_GMODE      8'h3a
`define TFSC_IDX_GMOD       8'h3b
`define TFSC_IDX_STATUS     8'h3c

// Reset values
`define TFSC_RST_ILLUM      8'h00
`define TFSC_RST_SEL2       8'h3a
`define TFSC_RST_MOD2       8'h00
`define TFSC_RST_SEL3       8'h00
`define TFSC_RST_MOD3       8'h3f
`define TFSC_RST_SEL4       8'h00
`define TFSC_RST_MOD4       8'h00
`define TFSC_RST_GMODE      8'h10
`define TFSC_RST_GMOD       8'h00

// Field positions
`define TFSC_BIT_HOLD_ON    6
`define TFSC_BIT_HOLD_OFF   7

// Grayscale readout mode codes
`define TFSC_GM_DIFF        8'h00
`define TFSC_GM_SINGLE      8'h10
`define TFSC_GM_DIFF_SUPP   8'h30

`endif

//--- hw/tfsc_pkg.sv
package tfsc_pkg;

    typedef enum logic [4:0] {
        TFSC_ST_IDLE = 5'h01,
        TFSC_ST_F1   = 5'h02,
        TFSC_ST_F2   = 5'h04,
        TFSC_ST_F3   = 5'h08,
        TFSC_ST_F4   = 5'h10
    } tfsc_state_t;

endpackage

//--- hw/tfsc_rst_sync.sv
`timescale 1ns/1ps
module tfsc_rst_sync (
    // Clock and raw reset
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    // Released reset
    output logic      o_rst_n
);
    logic meta_n_ff;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_n_ff <= 1'b0;
            o_rst_n   <= 1'b0;
        end else begin
            meta_n_ff <= 1'b1;
            o_rst_n   <= meta_n_ff;
        end
    end
endmodule

//--- hw/tfsc_gray_decode.sv
`timescale 1ns/1ps
`include "tfsc_defines.svh"
module tfsc_gray_decode (
    // Mode code
    input  wire logic [7:0] i_mode,
    // Decoded readout controls
    output logic            o_differential,
    output logic            o_clip_negative,
    output logic            o_bg_suppress
);
    always_comb begin
        o_differential  = 1'b1;
        o_clip_negative = 1'b0;
        o_bg_suppress   = 1'b0;
        case (i_mode)
            `TFSC_GM_SINGLE: begin
                o_differential  = 1'b0;
                o_clip_negative = 1'b1;
            end
            `TFSC_GM_DIFF_SUPP: begin
                o_bg_suppress   = 1'b1;
            end
            default: begin
                o_differential  = 1'b1;
            end
        endcase
    end
endmodule

//--- hw/tfsc_top.sv
`timescale 1ns/1ps
`include "tfsc_defines.svh"
module tfsc_top (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic [31:0]      o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Sequencer handshake
    input  wire logic        i_seq_start,
    input  wire logic        i_frame_next,
    input  wire logic        i_gray_seq,
    input  wire logic [7:0]  i_frame1_phase_select,
    input  wire logic [7:0]  i_frame1_mod_ctrl,
    // Active frame controls
    output logic [3:0]       o_frame_onehot,
    output logic [7:0]       o_phase_select,
    output logic [7:0]       o_mod_ctrl,
    output logic             o_light_modulated,
    output logic             o_light_hold_on,
    output logic             o_light_hold_off,
    output logic             o_gray_differential,
    output logic             o_gray_clip_negative,
    output logic             o_gray_bg_suppress
);
    logic                 rst_n;
    tfsc_pkg::tfsc_state_t state_ff;
    tfsc_pkg::tfsc_state_t nxt_state;

    // Software registers
    logic [1:0] illum_ff;
    logic [7:0] sel2_ff, mod2_ff, sel3_ff, mod3_ff, sel4_ff, mod4_ff, gmode_ff, gmod_ff;

    // Shadow copies used by the running sequence
    logic [1:0] sh_illum_ff, nxt_sh_illum;
    logic [7:0] sh_sel1_ff, sh_mod1_ff, sh_sel2_ff, sh_mod2_ff, sh_sel3_ff;
    logic [7:0] sh_mod3_ff, sh_sel4_ff, sh_mod4_ff, sh_gmode_ff, sh_gmod_ff;
    logic [7:0] nxt_sh_sel1, nxt_sh_mod1, nxt_sh_sel2, nxt_sh_mod2, nxt_sh_sel3;
    logic [7:0] nxt_sh_mod3, nxt_sh_sel4, nxt_sh_mod4, nxt_sh_gmode, nxt_sh_gmod;
    logic       sh_gray_ff, nxt_sh_gray;

    // Bus pipeline
    logic       addr_ok;
    logic [7:0] addr_idx;
    logic       wr_pend_ff;
    logic [7:0] wr_idx_ff;
    logic [7:0] rd_val;

    logic       start_take;
    logic [7:0] nxt_phase_select;
    logic [7:0] nxt_mod_ctrl;
    logic       dec_diff, dec_clip, dec_supp;

    tfsc_rst_sync u_rst_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .o_rst_n    (rst_n)
    );

    tfsc_gray_decode u_gray_decode (
        .i_mode          (nxt_sh_gmode),
        .o_differential  (dec_diff),
        .o_clip_negative (dec_clip),
        .o_bg_suppress   (dec_supp)
    );

    // Address phase decode
    assign addr_ok  = i_hsel && i_htrans[1] && i_hready && (i_haddr[1:0] == 2'b00)
                      && (i_haddr[31:10] == 22'h0) && (i_hsize == 3'b010);
    assign addr_idx = i_haddr[9:2];

    // Read mux, forwarding a write still in its data phase
    always_comb begin
        rd_val = 8'h00;
        if (wr_pend_ff && (wr_idx_ff == addr_idx)) begin
            rd_val = (addr_idx == `TFSC_IDX_ILLUM) ?
                     {i_hwdata[`TFSC_BIT_HOLD_OFF:`TFSC_BIT_HOLD_ON], 6'h00} :
                     i_hwdata[7:0];
        end else begin
            case (addr_idx)
                `TFSC_IDX_ILLUM:  rd_val = {illum_ff, 6'h00};
                `TFSC_IDX_SEL2:   rd_val = sel2_ff;
                `TFSC_IDX_MOD2:   rd_val = mod2_ff;
                `TFSC_IDX_SEL3:   rd_val = sel3_ff;
                `TFSC_IDX_MOD3:   rd_val = mod3_ff;
                `TFSC_IDX_SEL4:   rd_val = sel4_ff;
                `TFSC_IDX_MOD4:   rd_val = mod4_ff;
                `TFSC_IDX_GMODE:  rd_val = gmode_ff;
                `TFSC_IDX_GMOD:   rd_val = gmod_ff;
                `TFSC_IDX_STATUS: rd_val = {2'b00, sh_gray_ff, state_ff};
                default:          rd_val = 8'h00;
            endcase
        end
    end

    // Bus responses, zero wait states and always OKAY
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_hrdata    <= 32'h0000_0000;
            o_hreadyout <= 1'b0;
            o_hresp     <= 1'b0;
            wr_pend_ff  <= 1'b0;
            wr_idx_ff   <= 8'h00;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
            wr_pend_ff  <= addr_ok && i_hwrite;
            wr_idx_ff   <= addr_idx;
            if (i_hsel && i_htrans[1] && i_hready && !i_hwrite) begin
                o_hrdata <= addr_ok ? {24'h00_0000, rd_val} : 32'h0000_0000;
            end
        end
    end

    // Register writes in the data phase
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            illum_ff <= 2'b00;
            sel2_ff  <= `TFSC_RST_SEL2;
            mod2_ff  <= `TFSC_RST_MOD2;
            sel3_ff  <= `TFSC_RST_SEL3;
            mod3_ff  <= `TFSC_RST_MOD3;
            sel4_ff  <= `TFSC_RST_SEL4;
            mod4_ff  <= `TFSC_RST_MOD4;
            gmode_ff <= `TFSC_RST_GMODE;
            gmod_ff  <= `TFSC_RST_GMOD;
        end else if (wr_pend_ff) begin
            case (wr_idx_ff)
                `TFSC_IDX_ILLUM: illum_ff <= i_hwdata[`TFSC_BIT_HOLD_OFF:`TFSC_BIT_HOLD_ON];
                `TFSC_IDX_SEL2:  sel2_ff  <= i_hwdata[7:0];
                `TFSC_IDX_MOD2:  mod2_ff  <= i_hwdata[7:0];
                `TFSC_IDX_SEL3:  sel3_ff  <= i_hwdata[7:0];
                `TFSC_IDX_MOD3:  mod3_ff  <= i_hwdata[7:0];
                `TFSC_IDX_SEL4:  sel4_ff  <= i_hwdata[7:0];
                `TFSC_IDX_MOD4:  mod4_ff  <= i_hwdata[7:0];
                `TFSC_IDX_GMODE: gmode_ff <= i_hwdata[7:0];
                `TFSC_IDX_GMOD:  gmod_ff  <= i_hwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Sequence start only from idle
    assign start_take = i_seq_start && (state_ff == tfsc_pkg::TFSC_ST_IDLE);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            tfsc_pkg::TFSC_ST_IDLE: if (start_take) nxt_state = tfsc_pkg::TFSC_ST_F1;
            tfsc_pkg::TFSC_ST_F1:   if (i_frame_next) nxt_state = tfsc_pkg::TFSC_ST_F2;
            tfsc_pkg::TFSC_ST_F2:   if (i_frame_next) nxt_state = tfsc_pkg::TFSC_ST_F3;
            tfsc_pkg::TFSC_ST_F3:   if (i_frame_next) nxt_state = tfsc_pkg::TFSC_ST_F4;
            tfsc_pkg::TFSC_ST_F4:   if (i_frame_next) nxt_state = tfsc_pkg::TFSC_ST_IDLE;
            default:                nxt_state = tfsc_pkg::TFSC_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= tfsc_pkg::TFSC_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Shadow capture at sequence start
    always_comb begin
        nxt_sh_illum = start_take ? illum_ff : sh_illum_ff;
        nxt_sh_sel1  = start_take ? i_frame1_phase_select : sh_sel1_ff;
        nxt_sh_mod1  = start_take ? i_frame1_mod_ctrl : sh_mod1_ff;
        nxt_sh_sel2  = start_take ? sel2_ff : sh_sel2_ff;
        nxt_sh_mod2  = start_take ? mod2_ff : sh_mod2_ff;
        nxt_sh_sel3  = start_take ? sel3_ff : sh_sel3_ff;
        nxt_sh_mod3  = start_take ? mod3_ff : sh_mod3_ff;
        nxt_sh_sel4  = start_take ? sel4_ff : sh_sel4_ff;
        nxt_sh_mod4  = start_take ? mod4_ff : sh_mod4_ff;
        nxt_sh_gmode = start_take ? gmode_ff : sh_gmode_ff;
        nxt_sh_gmod  = start_take ? gmod_ff : sh_gmod_ff;
        nxt_sh_gray  = start_take ? i_gray_seq : sh_gray_ff;
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_illum_ff <= 2'b00;
            sh_sel1_ff  <= 8'h00;
            sh_mod1_ff  <= 8'h00;
            sh_sel2_ff  <= `TFSC_RST_SEL2;
            sh_mod2_ff  <= `TFSC_RST_MOD2;
            sh_sel3_ff  <= `TFSC_RST_SEL3;
            sh_mod3_ff  <= `TFSC_RST_MOD3;
            sh_sel4_ff  <= `TFSC_RST_SEL4;
            sh_mod4_ff  <= `TFSC_RST_MOD4;
            sh_gmode_ff <= `TFSC_RST_GMODE;
            sh_gmod_ff  <= `TFSC_RST_GMOD;
            sh_gray_ff  <= 1'b0;
        end else begin
            sh_illum_ff <= nxt_sh_illum;
            sh_sel1_ff  <= nxt_sh_sel1;
            sh_mod1_ff  <= nxt_sh_mod1;
            sh_sel2_ff  <= nxt_sh_sel2;
            sh_mod2_ff  <= nxt_sh_mod2;
            sh_sel3_ff  <= nxt_sh_sel3;
            sh_mod3_ff  <= nxt_sh_mod3;
            sh_sel4_ff  <= nxt_sh_sel4;
            sh_mod4_ff  <= nxt_sh_mod4;
            sh_gmode_ff <= nxt_sh_gmode;
            sh_gmod_ff  <= nxt_sh_gmod;
            sh_gray_ff  <= nxt_sh_gray;
        end
    end

    // Per-frame selection for the frame about to run
    always_comb begin
        nxt_phase_select = 8'h00;
        nxt_mod_ctrl     = 8'h00;
        case (nxt_state)
            tfsc_pkg::TFSC_ST_F1: begin
                nxt_phase_select = nxt_sh_sel1;
                nxt_mod_ctrl     = nxt_sh_mod1;
            end
            tfsc_pkg::TFSC_ST_F2: begin
                nxt_phase_select = nxt_sh_sel2;
                nxt_mod_ctrl     = nxt_sh_mod2;
            end
            tfsc_pkg::TFSC_ST_F3: begin
                nxt_phase_select = nxt_sh_sel3;
                nxt_mod_ctrl     = nxt_sh_mod3;
            end
            tfsc_pkg::TFSC_ST_F4: begin
                nxt_phase_select = nxt_sh_sel4;
                nxt_mod_ctrl     = nxt_sh_mod4;
            end
            default: begin
            end
        endcase
        if (nxt_sh_gray && (nxt_state != tfsc_pkg::TFSC_ST_IDLE)) begin
            nxt_mod_ctrl = nxt_sh_gmod;
        end
    end

    // Registered outputs
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_frame_onehot       <= 4'h0;
            o_phase_select       <= 8'h00;
            o_mod_ctrl           <= 8'h00;
            o_light_modulated    <= 1'b1;
            o_light_hold_on      <= 1'b0;
            o_light_hold_off     <= 1'b0;
            o_gray_differential  <= 1'b0;
            o_gray_clip_negative <= 1'b1;
            o_gray_bg_suppress   <= 1'b0;
        end else begin
            o_frame_onehot       <= nxt_state[4:1];
            o_phase_select       <= nxt_phase_select;
            o_mod_ctrl           <= nxt_mod_ctrl;
            o_light_modulated    <= (nxt_sh_illum == 2'b00);
            o_light_hold_on      <= nxt_sh_illum[0] && !nxt_sh_illum[1];
            o_light_hold_off     <= nxt_sh_illum[1];
            o_gray_differential  <= dec_diff;
            o_gray_clip_negative <= dec_clip;
            o_gray_bg_suppress   <= dec_supp;
        end
    end

    a_light_hold_on: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        start_take && illum_ff == 2'b01 |=> o_light_hold_on && !o_light_modulated)
        else $error("light not held on");

    a_light_hold_off: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        start_take && illum_ff[1] |=> o_light_hold_off && !o_light_hold_on)
        else $error("light not held off");

    a_reserved_ignored: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        wr_pend_ff && wr_idx_ff == `TFSC_IDX_ILLUM |=> illum_ff == $past(i_hwdata[7:6]))
        else $error("illumination field wrong");

    a_frame3_select: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        state_ff == tfsc_pkg::TFSC_ST_F3 |-> o_phase_select == sh_sel3_ff && o_frame_onehot == 4'h4)
        else $error("frame three select wrong");

    a_frame4_mod: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        state_ff == tfsc_pkg::TFSC_ST_F4 && !sh_gray_ff |-> o_mod_ctrl == sh_mod4_ff)
        else $error("frame four modulation wrong");

    a_gray_diff: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        start_take && gmode_ff == `TFSC_GM_DIFF |=> o_gray_differential && !o_gray_bg_suppress)
        else $error("differential mode wrong");

    a_gray_single: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        start_take && gmode_ff == `TFSC_GM_SINGLE |=> o_gray_clip_negative && !o_gray_differential)
        else $error("single ended mode wrong");

    a_gray_suppress: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        start_take && gmode_ff == `TFSC_GM_DIFF_SUPP |=> o_gray_differential && o_gray_bg_suppress)
        else $error("suppression mode wrong");

    a_gray_mod_used: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        state_ff != tfsc_pkg::TFSC_ST_IDLE && sh_gray_ff |-> o_mod_ctrl == sh_gmod_ff)
        else $error("grayscale modulation not used");

    a_shadow_frozen: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        state_ff != tfsc_pkg::TFSC_ST_IDLE |=> $stable(o_light_hold_off) && $stable(sh_gmode_ff)
        && $stable(o_gray_bg_suppress) && $stable(sh_sel2_ff))
        else $error("settings changed mid sequence");
endmodule

//--- bench/tb_tof_frame_sequence_config.sv
`timescale 1ns/1ps
`include "tfsc_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_tof_frame_sequence_config;
    logic        i_core_clk, i_rst_n, i_hsel, i_hwrite, i_hready;
    logic [31:0] i_haddr, i_hwdata, o_hrdata;
    logic [1:0]  i_htrans;
    logic [2:0]  i_hsize;
    logic        o_hreadyout, o_hresp, i_seq_start, i_frame_next, i_gray_seq;
    logic [7:0]  i_frame1_phase_select, i_frame1_mod_ctrl, o_phase_select, o_mod_ctrl;
    logic [3:0]  o_frame_onehot;
    logic        o_light_modulated, o_light_hold_on, o_light_hold_off;
    logic        o_gray_differential, o_gray_clip_negative, o_gray_bg_suppress;
    int          err_total, comparisons, frame;
    integer      seed;
    logic [7:0]  mdl [0:255];
    logic [7:0]  msk [0:255];
    logic [7:0]  shd [0:255];
    logic [7:0]  ph_q [$];
    logic [7:0]  md_q [$];
    logic        gray_sh;
    logic [31:0] rd;
    logic [7:0]  idx [0:8] = '{8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2d, 8'h2e, 8'h3a, 8'h3b};
    logic [7:0]  rst [0:8] = '{8'h00, 8'h3a, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h00, 8'h10, 8'h00};
    logic [7:0]  ilv [0:3] = '{8'h00, 8'h40, 8'h80, 8'hc0};
    logic [7:0]  gmv [0:2] = '{8'h00, 8'h10, 8'h30};

    assign i_hready = o_hreadyout;

    tfsc_top tfsc_top_inst (.*);

    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end

    task finish_test();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_core_clk);
        err_total++;
        finish_test();
    end

    task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge i_core_clk);
        i_hsel   <= 1'b1;
        i_htrans <= 2'b10;
        i_haddr  <= a;
        i_hwrite <= wr;
        do @(posedge i_core_clk); while (i_hready !== 1'b1);
        i_hsel   <= 1'b0;
        i_htrans <= 2'b00;
        i_hwdata <= wd;
        do @(posedge i_core_clk); while (i_hready !== 1'b1);
        rd = o_hrdata;
        `CHK(o_hresp, 1'b0)
    endtask

    task wreg(input logic [7:0] x, input logic [7:0] v);
        bus(1'b1, {22'h0, x, 2'b00}, {$random(seed)} & 32'hffffff00 | v);
        mdl[x] = (v & msk[x]) | (mdl[x] & ~msk[x]);
    endtask

    task rreg(input logic [7:0] x);
        bus(1'b0, {22'h0, x, 2'b00}, 32'h0);
        if (x == 8'h3c) `CHK(rd[5:0], {gray_sh, (frame == 0) ? 5'h01 : 5'(1 << frame)})
        else `CHK(rd, {24'h0, mdl[x]})
    endtask

    task chk();
        @(negedge i_core_clk);
        `CHK(o_frame_onehot, (frame == 0) ? 4'h0 : 4'(1 << (frame - 1)))
        `CHK(o_phase_select, (frame == 0) ? 8'h00 : ph_q[frame - 1])
        `CHK(o_mod_ctrl, (frame == 0) ? 8'h00 : md_q[frame - 1])
        `CHK(o_light_modulated, shd[8'h27][7:6] == 2'b00)
        `CHK(o_light_hold_on, shd[8'h27][7:6] == 2'b01)
        `CHK(o_light_hold_off, shd[8'h27][7])
        `CHK(o_gray_differential, shd[8'h3a] != 8'h10)
        `CHK(o_gray_clip_negative, shd[8'h3a] == 8'h10)
        `CHK(o_gray_bg_suppress, shd[8'h3a] == 8'h30)
    endtask

    task start_seq(input logic g);
        logic [7:0] p, m;
        p = $random(seed);
        m = $random(seed);
        @(posedge i_core_clk);
        i_gray_seq            <= g;
        i_frame1_phase_select <= p;
        i_frame1_mod_ctrl     <= m;
        i_seq_start           <= 1'b1;
        @(posedge i_core_clk);
        i_seq_start           <= 1'b0;
        i_frame1_phase_select <= ~p;
        i_gray_seq            <= ~g;
        if (frame == 0) begin
            shd = mdl;
            gray_sh = g;
            ph_q = '{p, shd[8'h28], shd[8'h2a], shd[8'h2d]};
            md_q = '{m, shd[8'h29], shd[8'h2b], shd[8'h2e]};
            if (g) md_q = '{shd[8'h3b], shd[8'h3b], shd[8'h3b], shd[8'h3b]};
            frame = 1;
        end
    endtask

    task next_frame();
        @(posedge i_core_clk);
        i_frame_next <= 1'b1;
        @(posedge i_core_clk);
        i_frame_next <= 1'b0;
        if (frame != 0) frame = (frame + 1) % 5;
    endtask

    initial begin
        seed = 32'hc68f8a82;
        {i_rst_n, i_hsel, i_hwrite, i_seq_start, i_frame_next, i_gray_seq} = '0;
        {i_haddr, i_hwdata, i_htrans, i_frame1_phase_select, i_frame1_mod_ctrl} = '0;
        i_hsize = 3'b010;
        err_total = 0;
        comparisons = 0;
        frame = 0;
        gray_sh = 1'b0;
        for (int k = 0; k < 256; k++) begin
            mdl[k] = 8'h00;
            msk[k] = 8'h00;
        end
        for (int k = 0; k < 9; k++) begin
            mdl[idx[k]] = rst[k];
            msk[idx[k]] = (k == 0) ? 8'hc0 : 8'hff;
        end
        shd = mdl;
        @(negedge i_core_clk);
        `CHK(o_hreadyout, 1'b0)
        repeat (2) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        for (int k = 0; k < 9; k++) rreg(idx[k]);
        rreg(8'h3c);
        chk();
        wreg(8'h2c, 8'h5a);
        rreg(8'h2c);
        wreg(8'h3c, 8'hff);
        rreg(8'h3c);
        bus(1'b1, 32'h400, 32'hffffffff);
        bus(1'b0, 32'h400, 32'h0);
        `CHK(rd, 32'h0)
        next_frame();
        chk();
        for (int i = 0; i < 6; i++) begin
            wreg(8'h27, ilv[i % 4] | (8'($random(seed)) & 8'h3f));
            for (int k = 1; k < 9; k++) wreg(idx[k], (k == 7) ? gmv[i % 3] : 8'($random(seed)));
            for (int k = 0; k < 9; k++) rreg(idx[k]);
            chk();
            start_seq(i[0]);
            chk();
            wreg(idx[i + 1], 8'($random(seed)));
            start_seq(~i[0]);
            chk();
            rreg(8'h3c);
            for (int f = 0; f < 4; f++) begin
                next_frame();
                chk();
            end
            rreg(8'h3c);
        end
        finish_test();
    end
endmodule
